// ===== src/uifc_pkg.sv
// Behaviour
// - Read low nibble gives top pending cause: 0001 none, 0010 tx empty, 0100 rx data.
// - Cause codes 0110 line status, 0111 busy detect, 1100 character timeout.
// - Written bit 3 picks DMA request mode 0 or mode 1 for both requests.
// - Writing one to bit 2 resets transmit queue control; bit self-clears.
// - Writing one to bit 1 resets receive queue control; bit self-clears.
// - Bit 0 enables both queues, resets to one; any change resets both queues.
// - Write-only bits 5:4 set transmit empty threshold: empty, two, quarter, half.
// - Write bits 7:6 set receive trigger: one, quarter, half, two below full.
package uifc_pkg;

  localparam int unsigned DEPTH_DEFAULT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_IDENT_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;

  // Control field positions
  localparam int unsigned BIT_QUEUE_ENABLE = 0;
  localparam int unsigned BIT_RX_RESET     = 1;
  localparam int unsigned BIT_TX_RESET     = 2;
  localparam int unsigned BIT_DMA_MODE     = 3;
  localparam int unsigned TET_LSB          = 4;
  localparam int unsigned RT_LSB           = 6;

  // Reset values
  localparam logic       RST_QUEUE_ENABLE = 1'h1;
  localparam logic       RST_DMA_MODE     = 1'h0;
  localparam logic [1:0] RST_TET          = 2'h0;
  localparam logic [1:0] RST_RT           = 2'h0;

  // Read-side queue enabled status
  localparam logic [1:0] QUEUES_ON  = 2'h3;
  localparam logic [1:0] QUEUES_OFF = 2'h0;

  typedef enum logic [3:0] {
    ID_NONE    = 4'h1,
    ID_THRE    = 4'h2,
    ID_RDA     = 4'h4,
    ID_RLS     = 4'h6,
    ID_BUSY    = 4'h7,
    ID_TIMEOUT = 4'hc
  } uifc_int_id_t;

  // Sticky event bits
  localparam int unsigned EV_RDA     = 0;
  localparam int unsigned EV_THRE    = 1;
  localparam int unsigned EV_RLS     = 2;
  localparam int unsigned EV_TIMEOUT = 3;
  localparam int unsigned EV_BUSY    = 4;
  localparam int unsigned NUM_EV     = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Receive trigger fill level in characters
  function automatic int unsigned rx_trig_count(input logic [1:0] sel, input int unsigned depth);
    case (sel)
      2'h0:    return 1;
      2'h1:    return depth / 4;
      2'h2:    return depth / 2;
      default: return depth - 2;
    endcase
  endfunction

  // Transmit empty threshold in characters
  function automatic int unsigned tx_empty_count(input logic [1:0] sel, input int unsigned depth);
    case (sel)
      2'h0:    return 0;
      2'h1:    return 2;
      2'h2:    return depth / 4;
      default: return depth / 2;
    endcase
  endfunction

endpackage

// ===== src/uifc_ahb_slave.sv
`timescale 1ns/100ps
module uifc_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] rd_data,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             wr_en,
  output logic             rd_en,
  output logic [7:0]       acc_addr
);
  import uifc_pkg::*;

  logic        accept;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic        ready_q;
  logic [31:0] rdata_q;

  assign accept = hsel & htrans[1] & hready;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture; part-word writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= accept & hwrite & (hsize == HSIZE_WORD);
      rd_pend_q <= accept & ~hwrite;
      if (accept) begin
        addr_q <= haddr;
      end
    end
  end

  // One wait state on reads so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      ready_q <= ~(accept & ~hwrite);
      if (rd_pend_q) begin
        rdata_q <= rd_data;
      end
    end
  end

  assign hreadyout = ready_q;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign wr_en     = wr_pend_q;
  assign rd_en     = rd_pend_q;
  assign acc_addr  = addr_q;

endmodule

// ===== src/uifc_irq_bank.sv
`timescale 1ns/100ps
module uifc_irq_bank #(
  parameter int unsigned N = 5
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [N-1:0] ev_set,
  input  wire logic         clr_wr,
  input  wire logic         en_wr,
  input  wire logic [N-1:0] wdata,
  output logic [N-1:0]      status,
  output logic [N-1:0]      enable,
  output logic              irq
);
  import uifc_pkg::*;

  logic [N-1:0] status_q;
  logic [N-1:0] enable_q;
  logic         irq_q;

  // Set beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(clr_wr ? wdata : '0)) | ev_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= '0;
    end else if (en_wr) begin
      enable_q <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & enable_q);
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq    = irq_q;

endmodule

// ===== src/uifc_ident_ctrl.sv
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module uifc_ident_ctrl #(
  parameter int unsigned DEPTH = uifc_pkg::DEPTH_DEFAULT,
  parameter int unsigned LW    = $clog2(DEPTH) + 1
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire logic [LW-1:0] tx_level,
  input  wire logic [LW-1:0] rx_level,
  input  wire logic          line_status_cond,
  input  wire logic          busy_detect_cond,
  input  wire logic          char_timeout_cond,
  output logic               tx_queue_reset,
  output logic               rx_queue_reset,
  output logic               queue_enable,
  output logic               dma_signal_mode,
  output logic               dma_tx_req_n,
  output logic               dma_rx_req_n,
  output logic               rx_flow_stop,
  output logic               irq
);
  import uifc_pkg::*;

  logic                  wr_en;
  logic                  rd_en;
  logic [7:0]            acc_addr;
  logic [31:0]           rd_data;
  logic                  ctrl_wr;
  logic                  queue_enable_q;
  logic                  dma_mode_q;
  logic [1:0]            tx_empty_threshold_q;
  logic [1:0]            rx_trigger_level_q;
  logic                  tx_queue_reset_q;
  logic                  rx_queue_reset_q;
  logic                  dma_tx_req_n_q;
  logic                  dma_rx_req_n_q;
  logic                  rx_flow_stop_q;
  logic                  rda_pend;
  logic                  thre_pend;
  logic                  rx_at_trigger;
  logic                  tx_at_threshold;
  logic [NUM_EV-1:0]     cond_now;
  logic [NUM_EV-1:0]     cond_q;
  logic [NUM_EV-1:0]     irq_status;
  logic [NUM_EV-1:0]     irq_enable;
  uifc_int_id_t          interrupt_ident;
  int unsigned           tx_cnt;
  int unsigned           rx_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  uifc_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr[7:0]),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rd_data   (rd_data),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .acc_addr  (acc_addr)
  );

  assign ctrl_wr = wr_en & (acc_addr == OFS_IDENT_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Write-side control storage

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      queue_enable_q       <= RST_QUEUE_ENABLE;
      dma_mode_q           <= RST_DMA_MODE;
      tx_empty_threshold_q <= RST_TET;
      rx_trigger_level_q   <= RST_RT;
    end else if (ctrl_wr) begin
      queue_enable_q       <= hwdata[BIT_QUEUE_ENABLE];
      dma_mode_q           <= hwdata[BIT_DMA_MODE];
      tx_empty_threshold_q <= hwdata[TET_LSB +: 2];
      rx_trigger_level_q   <= hwdata[RT_LSB +: 2];
    end
  end

  // Reset pulses last one cycle; nothing stored, so nothing to clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_queue_reset_q <= 1'b0;
      rx_queue_reset_q <= 1'b0;
    end else begin
      tx_queue_reset_q <= ctrl_wr & (hwdata[BIT_TX_RESET] |
                          (hwdata[BIT_QUEUE_ENABLE] != queue_enable_q));
      rx_queue_reset_q <= ctrl_wr & (hwdata[BIT_RX_RESET] |
                          (hwdata[BIT_QUEUE_ENABLE] != queue_enable_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fill level comparisons

  always_comb begin
    tx_cnt = tx_empty_count(tx_empty_threshold_q, DEPTH);
    rx_cnt = rx_trig_count(rx_trigger_level_q, DEPTH);
  end

  assign rx_at_trigger   = queue_enable_q ? (int'(rx_level) >= rx_cnt) : (rx_level != '0);
  assign tx_at_threshold = queue_enable_q ? (int'(tx_level) <= tx_cnt) : (tx_level == '0);

  assign rda_pend  = rx_at_trigger;
  assign thre_pend = tx_at_threshold;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt identification, highest priority first

  always_comb begin
    if (line_status_cond) begin
      interrupt_ident = ID_RLS;
    end else if (rda_pend) begin
      interrupt_ident = ID_RDA;
    end else if (char_timeout_cond) begin
      interrupt_ident = ID_TIMEOUT;
    end else if (thre_pend) begin
      interrupt_ident = ID_THRE;
    end else if (busy_detect_cond) begin
      interrupt_ident = ID_BUSY;
    end else begin
      interrupt_ident = ID_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    rd_data = 32'h0;
    unique case (acc_addr)
      // Read shows cause and enable status
      OFS_IDENT_CTRL: rd_data = {24'h0, queue_enable_q ? QUEUES_ON : QUEUES_OFF,
                                 2'h0, interrupt_ident};
      OFS_IRQ_STATUS: rd_data = {{(32-NUM_EV){1'b0}}, irq_status};
      OFS_IRQ_ENABLE: rd_data = {{(32-NUM_EV){1'b0}}, irq_enable};
      default:        rd_data = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA requests and flow control

  // Mode 0 follows the level; mode 1 holds until the queue drains or fills,
  // which avoids a burst being cut off at the threshold edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_rx_req_n_q <= 1'b1;
      dma_tx_req_n_q <= 1'b1;
    end else if (!dma_mode_q) begin
      dma_rx_req_n_q <= rx_level == '0;
      dma_tx_req_n_q <= tx_level != '0;
    end else begin
      if (rx_at_trigger | char_timeout_cond) begin
        dma_rx_req_n_q <= 1'b0;
      end else if (rx_level == '0) begin
        dma_rx_req_n_q <= 1'b1;
      end
      if (tx_at_threshold) begin
        dma_tx_req_n_q <= 1'b0;
      end else if (int'(tx_level) >= DEPTH) begin
        dma_tx_req_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_flow_stop_q <= 1'b0;
    end else begin
      rx_flow_stop_q <= queue_enable_q & rx_at_trigger;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events on rising edges of each cause

  always_comb begin
    cond_now             = '0;
    cond_now[EV_RDA]     = rda_pend;
    cond_now[EV_THRE]    = thre_pend;
    cond_now[EV_RLS]     = line_status_cond;
    cond_now[EV_TIMEOUT] = char_timeout_cond;
    cond_now[EV_BUSY]    = busy_detect_cond;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond_now;
    end
  end

  uifc_irq_bank #(
    .N (NUM_EV)
  ) u_irq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ev_set  (cond_now & ~cond_q),
    .clr_wr  (wr_en & (acc_addr == OFS_IRQ_CLEAR)),
    .en_wr   (wr_en & (acc_addr == OFS_IRQ_ENABLE)),
    .wdata   (hwdata[NUM_EV-1:0]),
    .status  (irq_status),
    .enable  (irq_enable),
    .irq     (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign tx_queue_reset  = tx_queue_reset_q;
  assign rx_queue_reset  = rx_queue_reset_q;
  assign queue_enable    = queue_enable_q;
  assign dma_signal_mode = dma_mode_q;
  assign dma_tx_req_n    = dma_tx_req_n_q;
  assign dma_rx_req_n    = dma_rx_req_n_q;
  assign rx_flow_stop    = rx_flow_stop_q;

endmodule

// ===== verification/uifc_ident_ctrl_assertions.sv
`timescale 1ns/100ps
module uifc_ident_ctrl_assertions #(
  parameter int unsigned LW = 5
) (
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire logic [31:0]   hrdata,
  input wire logic [LW-1:0] tx_level,
  input wire logic [LW-1:0] rx_level,
  input wire logic          tx_queue_reset,
  input wire logic          rx_queue_reset,
  input wire logic          queue_enable,
  input wire logic          dma_signal_mode,
  input wire logic          dma_tx_req_n,
  input wire logic          dma_rx_req_n,
  input wire logic          rx_flow_stop
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_id;
  assign rd_id = hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  property p_tx_pulse;
    tx_queue_reset |=> !tx_queue_reset;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("tx queue reset held too long");
  property p_rx_pulse;
    rx_queue_reset |=> !rx_queue_reset;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("rx queue reset held too long");
  property p_en_change;
    $changed(queue_enable) |-> tx_queue_reset && rx_queue_reset;
  endproperty
  a_en_change: assert property (p_en_change)
    else $error("enable change without both queue resets");
  property p_dma_rx0;
    !dma_signal_mode |=> dma_rx_req_n == $past(rx_level == '0);
  endproperty
  a_dma_rx0: assert property (p_dma_rx0)
    else $error("rx request wrong in mode 0");
  property p_dma_tx0;
    !dma_signal_mode |=> dma_tx_req_n == $past(tx_level != '0);
  endproperty
  a_dma_tx0: assert property (p_dma_tx0)
    else $error("tx request wrong in mode 0");
  property p_rd_wait;
    rd_id |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("ident read wait state wrong");
  property p_code;
    rd_id |-> ##2 hrdata[3:0] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'hc};
  endproperty
  a_code: assert property (p_code)
    else $error("illegal cause code");
  property p_ident;
    rd_id |-> ##2 (hrdata[7:6] == {2{$past(queue_enable)}} && hrdata[5:4] == 2'h0);
  endproperty
  a_ident: assert property (p_ident)
    else $error("ident read upper bits wrong");
  property p_flow;
    rx_flow_stop |-> $past(queue_enable) && $past(rx_level) != '0;
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow stop without enabled filled queue");
endmodule

// ===== verification/uifc_queue_model.sv
`timescale 1ns/100ps
module uifc_queue_model #(
  parameter int unsigned LW = 5
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          tx_queue_reset,
  input  wire logic          rx_queue_reset,
  input  wire logic          set_stb,
  input  wire logic [LW-1:0] set_tx,
  input  wire logic [LW-1:0] set_rx,
  output logic [LW-1:0]      tx_level,
  output logic [LW-1:0]      rx_level
);
  // Queue reset beats a level load in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_level <= '0;
      rx_level <= '0;
    end else begin
      if (set_stb) begin
        tx_level <= set_tx;
        rx_level <= set_rx;
      end
      if (tx_queue_reset) begin
        tx_level <= '0;
      end
      if (rx_queue_reset) begin
        rx_level <= '0;
      end
    end
  end
endmodule

// ===== verification/uifc_ident_ctrl_test.sv
`timescale 1ns/100ps
module uifc_ident_ctrl_test;
  import uifc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, set_stb = 0, rd_ph = 0;
  logic ls = 0, bz = 0, to = 0, hreadyout, hresp, txr, rxr, qen, dmode, txq_n, rxq_n, fst, irq;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rnd = 32'h3b46d9cf;
  logic [4:0] set_tx = '0, set_rx = '0, tx_level, rx_level;
  logic [31:0] eq[$], mq[$];
  logic [1:0] pq[$];
  logic [2:0] cnd[6] = '{3'b100, 3'b010, 3'b010, 3'b000, 3'b001, 3'b000};
  logic [3:0] code[6] = '{ID_RLS, ID_RDA, ID_TIMEOUT, ID_THRE, ID_BUSY, ID_NONE};
  int n_fail = 0, samples_checked = 0;
  uifc_ident_ctrl #(.DEPTH(16)) u_uifc_ident_ctrl (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tx_level(tx_level), .rx_level(rx_level), .line_status_cond(ls),
    .busy_detect_cond(bz), .char_timeout_cond(to), .tx_queue_reset(txr),
    .rx_queue_reset(rxr), .queue_enable(qen), .dma_signal_mode(dmode),
    .dma_tx_req_n(txq_n), .dma_rx_req_n(rxq_n), .rx_flow_stop(fst), .irq(irq));
  uifc_queue_model #(.LW(5)) u_uifc_queue_model (.hclk(hclk), .hresetn(hresetn),
    .tx_queue_reset(txr), .rx_queue_reset(rxr), .set_stb(set_stb), .set_tx(set_tx),
    .set_rx(set_rx), .tx_level(tx_level), .rx_level(rx_level));
  initial begin
    forever #25 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task end_of_test;
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Address phase held until ready, then data phase held until ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    bus(1'b0, a, '0);
  endtask
  task wrp(input logic [31:0] d, input logic [1:0] p);
    if (p != 2'h0) pq.push_back(p);
    bus(1'b1, 8'h00, d);
  endtask
  task lv(input logic [4:0] t, input logic [4:0] r);
    set_tx <= t;
    set_rx <= r;
    set_stb <= 1'b1;
    @(posedge hclk);
    set_stb <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin : mon
    logic [31:0] m;
    m = '1;
    if (rd_ph && hreadyout) begin
      m = mq.pop_front();
      chk(hrdata & m, eq.pop_front() & m);
    end
    if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
    if (txr || rxr) chk({30'h0, txr, rxr}, {30'h0, pq.size() ? pq.pop_front() : 2'h0});
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'hc2, '1);
    rd(8'h0c, 32'h0, '1);
    rd(8'h10, 32'h0, '1);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      {ls, to, bz} <= cnd[i];
      lv(i == 3 || i == 2 || i == 0 ? 5'h0 : 5'h1 + rnd[3:0], i < 2 ? 5'h1 + rnd[7:4] : 5'h0);
      rd(8'h00, {24'h0, 4'hc, code[i]}, '1);
    end
    {ls, to, bz} <= 3'h0;
    lv(5'h5, 5'h5);
    wrp(32'h05, 2'b10);
    wrp(32'h03, 2'b01);
    wrp(32'h00, 2'b11);
    rd(8'h00, 32'h02, '1);
    wrp(32'h01, 2'b11);
    wrp(32'h91, 2'b00);
    lv(5'h3, 5'h7);
    rd(8'h00, 32'hc1, '1);
    lv(5'h2, 5'h7);
    rd(8'h00, 32'hc2, '1);
    lv(5'h3, 5'h8);
    rd(8'h00, 32'hc4, '1);
    wrp(32'h99, 2'b00);
    lv(5'h3, 5'h8);
    chk({31'h0, rxq_n}, 32'h0);
    chk({31'h0, txq_n}, 32'h1);
    chk({31'h0, dmode}, 32'h1);
    chk({31'h0, fst}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    lv(5'h3, 5'h4);
    chk({31'h0, rxq_n}, 32'h0);
    lv(5'h3, 5'h0);
    chk({31'h0, rxq_n}, 32'h1);
    bus(1'b1, 8'h08, 32'h1f);
    bus(1'b1, 8'h0c, 32'h04);
    ls <= 1'b1;
    lv(5'h3, 5'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h04, 32'h04, 32'h04);
    bus(1'b1, 8'h0c, 32'h00);
    lv(5'h3, 5'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h0c, 32'h04);
    rd(8'h0c, 32'h04, '1);
    bus(1'b1, 8'h08, 32'h04);
    lv(5'h3, 5'h0);
    chk({31'h0, irq}, 32'h0);
    rd(8'h04, 32'h00, 32'h04);
    ls <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(32'(pq.size() + eq.size()), 32'h0);
    end_of_test;
  end
endmodule
bind uifc_ident_ctrl uifc_ident_ctrl_assertions #(.LW(LW)) u_uifc_ident_ctrl_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .tx_level(tx_level), .rx_level(rx_level), .tx_queue_reset(tx_queue_reset),
  .rx_queue_reset(rx_queue_reset), .queue_enable(queue_enable),
  .dma_signal_mode(dma_signal_mode), .dma_tx_req_n(dma_tx_req_n),
  .dma_rx_req_n(dma_rx_req_n), .rx_flow_stop(rx_flow_stop));
